// File: verilog/pac_top.sv
// Control, calibration, correction and output logic of the converter.
// Assumes the analog core delivers raw stage bits and range flags once per
// conversion tick, and a measured stage weight during calibration.
//
// How it works
// - A calibration lasts 4000 conversion ticks.
// - Words produced while calibrating are meaningless; ready flags them.
// - Calibration starts at reset release and on each valid request while converting.
// - Calibration stores one measured coefficient per raw stage bit.
// - Fifteen stages each supply one raw bit per conversion.
// - Raw bits weighted by coefficients form the 12-bit code.
// - A new word every tick, delayed by a fixed pipeline depth.
// - Outputs drive while output enable pin low, float when high.
// - Sleep request high holds idle with no conversions.
// - After sleep ends, conversion resumes within the wake time.
// - Pipeline contents are discarded on entering sleep.
// - Ready high only when converting; low in calibration or sleep.
// - Fourteen digital outputs: twelve data, ready, out of range.
// - Ready falls within three ticks of an accepted request.
// - Leaving sleep takes 4000 conversion ticks.
// - Result words are unsigned straight binary.
// - Out-of-range flag follows the core's range comparators.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
module pac_top #(
   parameter int CONV_DIV = pac_pkg::CONV_DIV,
   parameter int LATENCY = pac_pkg::LATENCY
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control pins
   input wire logic cal_request,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // Conversion core
   input wire pac_pkg::pac_raw_type raw,
   input wire logic [pac_pkg::COEF_W-1:0] stage_weight,
   output logic [3:0] stage_select,
   output logic core_sleep,
   // Result pins
   output pac_pkg::pac_result_type result,
   output logic result_oe
);
   import pac_pkg::*;

   pac_state_type state;
   logic [7:0] div_count;
   logic conv_tick;
   logic [11:0] cycle_count;
   logic [1:0] cal_hold;
   logic pin_cal_accept;
   logic sw_cal;
   logic sw_sleep;
   logic sleep_active;
   logic cal_accept;
   logic [3:0] coef_sel;
   logic [COEF_W-1:0] coef [STAGES];
   logic [COEF_W-1:0] term [STAGES];
   logic [COEF_W+3:0] sum;
   logic [DATA_W-1:0] next_code;
   logic [DATA_W:0] pipe [LATENCY];
   logic apb_setup;
   logic apb_write;
   logic ctrl_write;
   logic sel_write;
   logic [31:0] next_prdata;
   logic next_pslverr;

   assign sleep_active = sleep_request | sw_sleep;

   // Conversion rate as a one-cycle enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 8'h00;
         conv_tick <= 1'b0;
      end else if (div_count == 8'(CONV_DIV - 1)) begin
         div_count <= 8'h00;
         conv_tick <= 1'b1;
      end else begin
         div_count <= div_count + 8'h01;
         conv_tick <= 1'b0;
      end
   end

   // level hold count
   // Counts consecutive ticks with the pin high; fires once per assertion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_hold <= 2'b00;
         pin_cal_accept <= 1'b0;
      end else begin
         pin_cal_accept <= 1'b0;
         if (conv_tick) begin
            if (!cal_request) begin
               cal_hold <= 2'b00;
            end else if (cal_hold != 2'(CAL_HOLD_CYCLES)) begin
               cal_hold <= cal_hold + 2'b01;
               if (cal_hold == 2'(CAL_HOLD_CYCLES - 1)) begin
                  pin_cal_accept <= 1'b1;
               end
            end
         end
      end
   end

   assign cal_accept = pin_cal_accept | sw_cal;

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_CAL;
         cycle_count <= 12'h000;
      end else begin
         unique case (state)
            ST_CAL: begin
               if (sleep_active) begin
                  state <= ST_SLEEP;
                  cycle_count <= 12'h000;
               end else if (conv_tick) begin
                  if (cycle_count == 12'(CAL_CYCLES - 1)) begin
                     state <= ST_RUN;
                     cycle_count <= 12'h000;
                  end else begin
                     cycle_count <= cycle_count + 12'h001;
                  end
               end
            end
            ST_RUN: begin
               if (sleep_active) begin
                  state <= ST_SLEEP;
               end else if (cal_accept) begin
                  state <= ST_CAL;
                  cycle_count <= 12'h000;
               end
            end
            ST_SLEEP: begin
               if (!sleep_active) begin
                  state <= ST_WAKE;
                  cycle_count <= 12'h000;
               end
            end
            ST_WAKE: begin
               if (sleep_active) begin
                  state <= ST_SLEEP;
               end else if (conv_tick) begin
                  if (cycle_count == 12'(WAKE_CYCLES - 1)) begin
                     state <= ST_RUN;
                     cycle_count <= 12'h000;
                  end else begin
                     cycle_count <= cycle_count + 12'h001;
                  end
               end
            end
         endcase
      end
   end

   // coefficient capture
   // Each stage gets a 256-tick window; the weight is taken at its end
   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++) begin : g_stage
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               coef[gi] <= COEF_W'(16'h8000 >> gi);
            end else if (state == ST_CAL && conv_tick &&
                         cycle_count[11:8] == 4'(gi) &&
                         cycle_count[7:0] == 8'hff) begin
               coef[gi] <= stage_weight;
            end
         end
         assign term[gi] = raw.stage_bits[gi] ? coef[gi] : '0;
      end
   endgenerate

   // Calibration stage steering, parked at stage 0 outside calibration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_select <= 4'h0;
      end else begin
         stage_select <= (state == ST_CAL) ? cycle_count[11:8] : 4'h0;
      end
   end

   // Core power switch follows the sleep state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_sleep <= 1'b0;
      end else begin
         core_sleep <= (state == ST_SLEEP);
      end
   end

   // sum and saturate to unsigned code
   always_comb begin
      sum = '0;
      for (int i = 0; i < STAGES; i++) begin
         sum = sum + (COEF_W+4)'(term[i]);
      end
      if (sum[COEF_W+3:FRAC_W] > (COEF_W)'({DATA_W{1'b1}})) begin
         next_code = {DATA_W{1'b1}};
      end else begin
         next_code = sum[FRAC_W+DATA_W-1:FRAC_W];
      end
   end

   // flushed while asleep, so stale words never resurface
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < LATENCY; i++) begin
            pipe[i] <= '0;
         end
      end else if (state == ST_SLEEP) begin
         for (int i = 0; i < LATENCY; i++) begin
            pipe[i] <= '0;
         end
      end else if (conv_tick) begin
         // range flag travels with its sample
         pipe[0] <= {raw.below_ground | raw.above_ref, next_code};
         for (int i = 1; i < LATENCY; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= '0;
      end else begin
         // ready low while calibrating or asleep
         result.ready <= (state == ST_RUN) && !cal_accept && !sleep_active;
         if (conv_tick) begin
            result.out_of_range <= pipe[LATENCY-1][DATA_W];
            result.data <= pipe[LATENCY-1][DATA_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_oe <= 1'b0;
      end else begin
         result_oe <= !output_enable_n;
      end
   end

   // APB slave: one wait state, answer registered
   assign apb_setup = psel && !penable;
   // Writes land on the edge at which the master sees pready high
   assign apb_write = psel && penable && pwrite && pready;
   assign ctrl_write = apb_write && (paddr == CTRL_OFS);
   assign sel_write = apb_write && (paddr == COEF_SEL_OFS);

   // One-cycle software calibration strike
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_cal <= 1'b0;
      end else begin
         // Software request is taken as already qualified
         sw_cal <= ctrl_write && pwdata[CTRL_CAL_BIT];
      end
   end

   // Software sleep level, ORed with the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_sleep <= CTRL_SLEEP_RESET;
      end else if (ctrl_write) begin
         sw_sleep <= pwdata[CTRL_SLEEP_BIT];
      end
   end

   // Coefficient read-back selector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coef_sel <= COEF_SEL_RESET;
      end else if (sel_write) begin
         coef_sel <= pwdata[3:0];
      end
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (paddr)
         CTRL_OFS: next_prdata[CTRL_SLEEP_BIT] = sw_sleep;
         STATUS_OFS: next_prdata = {12'h000, cycle_count, 3'h0,
                                    result.ready, 2'h0, state};
         RESULT_OFS: next_prdata = {18'h00000, result};
         COEF_SEL_OFS: next_prdata = {28'h0000000, coef_sel};
         COEF_OFS: begin
            if (coef_sel < 4'(STAGES)) begin
               next_prdata = {16'h0000, coef[coef_sel]};
            end
         end
         default: next_pslverr = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Setup cycle decode drives nothing; kept for clarity of phases
   logic unused_setup;
   assign unused_setup = apb_setup;

endmodule

// File: verilog/pac_pkg.sv
// Shared constants and carrier types for the converter control block.
// Assumes a 200 MHz APB clock and a conversion rate derived from it.
package pac_pkg;

   // Clock rates and the conversion-rate divider
   localparam int PCLK_HZ = 200_000_000;
   localparam int CONV_CLK_HZ = 10_000_000;
   localparam int CONV_DIV = PCLK_HZ / CONV_CLK_HZ;

   // Sequence lengths in conversion clock cycles
   localparam int CAL_CYCLES = 4000;
   localparam int WAKE_CYCLES = 4000;
   localparam int CAL_HOLD_CYCLES = 3;
   localparam int LATENCY = 10;

   // Core geometry
   localparam int STAGES = 15;
   localparam int DATA_W = 12;
   localparam int COEF_W = 16;
   localparam int FRAC_W = 4;
   localparam int CAL_WINDOW_W = 8;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] RESULT_OFS = 8'h08;
   localparam logic [7:0] COEF_SEL_OFS = 8'h0c;
   localparam logic [7:0] COEF_OFS = 8'h10;

   // Control field positions and reset values
   localparam int CTRL_CAL_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam logic CTRL_SLEEP_RESET = 1'b0;
   localparam logic [3:0] COEF_SEL_RESET = 4'h0;

   typedef enum logic [1:0] {
      ST_CAL = 2'b00,
      ST_RUN = 2'b01,
      ST_SLEEP = 2'b10,
      ST_WAKE = 2'b11
   } pac_state_type;

   // One output word as seen on the pins
   typedef struct packed {
      logic ready;
      logic out_of_range;
      logic [DATA_W-1:0] data;
   } pac_result_type;

   // One raw sample from the conversion core
   typedef struct packed {
      logic below_ground;
      logic above_ref;
      logic [STAGES-1:0] stage_bits;
   } pac_raw_type;

endpackage

// File: verif/pac_chk.sv
// Port-level assertions for the converter control block.
// Bound into pac_top; sees only its ports.
`timescale 1ns/10ps
module pac_chk #(
   parameter int CONV_DIV = 20,
   parameter int LATENCY = 10
) (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic cal_request,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic [3:0] stage_select,
   input wire logic core_sleep,
   input wire pac_pkg::pac_result_type result,
   input wire logic result_oe
);
   import pac_pkg::*;
   int low_cnt;
   int hi_cnt;
   logic rdy_at_req;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Ready-low time, to bound every return of ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= result.ready ? 0 : low_cnt + 1;
      end
   end
   // Length of the current request and whether it met a ready device
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt <= 0;
         rdy_at_req <= 1'b0;
      end else begin
         hi_cnt <= cal_request ? hi_cnt + 1 : 0;
         if ($rose(cal_request)) begin
            rdy_at_req <= result.ready;
         end
      end
   end
   a_oe_follow: assert property (presetn |=>
      result_oe == !$past(output_enable_n)) else $error("oe mismatch");
   a_sleep_core: assert property (sleep_request |-> ##2 core_sleep)
      else $error("sleep not entered");
   a_sleep_ready: assert property (core_sleep |=> !result.ready)
      else $error("ready high in sleep");
   a_ready_drop: assert property (
      hi_cnt == 4 * CONV_DIV + 2 && rdy_at_req |-> !result.ready)
      else $error("ready did not drop");
   a_ready_wait: assert property ($rose(result.ready) |->
      low_cnt >= (CAL_CYCLES - 1) * CONV_DIV) else $error("ready early");
   a_stage_rest: assert property (
      result.ready |-> stage_select == 4'h0) else $error("stage busy");
   a_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready long");
   a_err_pair: assert property (pslverr |-> pready)
      else $error("lone error");
   cover property ($rose(result.ready));
   cover property ($rose(core_sleep));
   cover property (pslverr);
endmodule

bind pac_top pac_chk #(.CONV_DIV(CONV_DIV), .LATENCY(LATENCY)) u_pac_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .cal_request(cal_request),
   .output_enable_n(output_enable_n), .sleep_request(sleep_request),
   .stage_select(stage_select), .core_sleep(core_sleep),
   .result(result), .result_oe(result_oe));

// File: verif/pac_host.sv
// Host model: holds the calibration pin and keeps valid samples.
// Assumes the bench pulses cal_go with hold_len in pclk cycles.
`timescale 1ns/10ps
module pac_host (
   // Clock, reset and commands
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cal_go,
   input wire logic [15:0] hold_len,
   // Converter side
   input wire pac_pkg::pac_result_type result,
   output logic cal_request,
   output logic [11:0] last_good
);
   import pac_pkg::*;
   logic [15:0] hold_left;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_left <= 16'h0000;
      end else if (cal_go) begin
         hold_left <= hold_len;
      end else if (hold_left != 16'h0000) begin
         hold_left <= hold_left - 16'h0001;
      end
   end
   assign cal_request = hold_left != 16'h0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_good <= 12'h000;
      end else if (result.ready) begin
         last_good <= result.data;
      end
   end
endmodule

// File: verif/testbench.sv
// Bench: APB master, pin stimulus and host model around the converter.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module testbench;
   import pac_pkg::*;
   localparam int DIV = 2;
   localparam int LAT = 4;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, oe_n = 1'b0, slp = 1'b0, go = 1'b0, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, cal_req, core_sleep, result_oe;
   logic [3:0] sel;
   logic [15:0] hold = 16'h0000;
   logic [11:0] last_good;
   pac_raw_type raw = '0;
   pac_result_type result;
   int bad_count = 0, checks_done = 0, cyc = 0, t0;
   logic [16:0] rraw [6] = '{17'h00000, 17'h07fff, 17'h04001,
      17'h00080, 17'h10000, 17'h0ffff};
   logic [13:0] rexp [6] = '{14'h2000, 14'h27ff, 14'h2400,
      14'h2008, 14'h3000, 14'h37ff};
   wire logic [15:0] weight = 16'h4000 >> sel;
   pac_top #(.CONV_DIV(DIV), .LATENCY(LAT)) u_pac_top (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cal_request(cal_req), .output_enable_n(oe_n),
      .sleep_request(slp), .raw(raw), .stage_weight(weight),
      .stage_select(sel), .core_sleep(core_sleep), .result(result),
      .result_oe(result_oe));
   pac_host u_pac_host (.pclk(pclk), .presetn(presetn), .cal_go(go),
      .hold_len(hold), .result(result), .cal_request(cal_req),
      .last_good(last_good));
   always #2.5 pclk = ~pclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] inr(int v, int lo, int hi);
      return {31'h0, v >= lo && v <= hi};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_rdy(input logic lvl);
      while (result.ready !== lvl) @(posedge pclk);
   endtask
   task automatic cal(input int len);
      hold <= 16'(len);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
   endtask
   task automatic results();
      if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t0 = cyc;
      @(posedge pclk);
      check(result.ready, 1'b0);
      wait_rdy(1'b1);
      check(inr(cyc - t0, 3999 * DIV, 4002 * DIV), 1);
      check($bits(result), 14);
      apb(0, CTRL_OFS, 0);
      check(rd, {30'h0, CTRL_SLEEP_RESET, 1'b0});
      apb(0, COEF_SEL_OFS, 0);
      check(rd, {28'h0, COEF_SEL_RESET});
      apb(1, COEF_SEL_OFS, 3);
      apb(0, COEF_OFS, 0);
      check(rd, 32'h800);
      apb(1, COEF_SEL_OFS, 15);
      apb(0, COEF_OFS, 0);
      check(rd, 32'h0);
      apb(0, 8'h14, 0);
      check(er, 1'b1);
      for (int i = 0; i < 6; i++) begin
         raw <= rraw[i];
         repeat ((LAT + 2) * DIV) @(posedge pclk);
         check(result, rexp[i]);
      end
      check(last_good, 12'h7ff);
      apb(0, RESULT_OFS, 0);
      check(rd, {18'h0, rexp[5]});
      raw <= '0;
      repeat ((LAT + 2) * DIV) @(posedge pclk);
      raw <= 17'h07fff;
      t0 = cyc;
      while (result.data === 12'h000) @(posedge pclk);
      check(inr(cyc - t0, LAT * DIV - 1, (LAT + 2) * DIV), 1);
      oe_n <= 1'b1;
      repeat (2) @(posedge pclk);
      check(result_oe, 1'b0);
      oe_n <= 1'b0;
      repeat (2) @(posedge pclk);
      check(result_oe, 1'b1);
      cal(2 * DIV - 1);
      repeat (8 * DIV) @(posedge pclk);
      check(result.ready, 1'b1);
      cal(6 * DIV);
      t0 = cyc;
      wait_rdy(1'b0);
      check(inr(cyc - t0, 0, 4 * DIV + 2), 1);
      t0 = cyc;
      repeat (2000 * DIV) @(posedge pclk);
      cal(6 * DIV);
      wait_rdy(1'b1);
      check(inr(cyc - t0, 3999 * DIV, 4002 * DIV), 1);
      slp <= 1'b1;
      repeat (3) @(posedge pclk);
      check({core_sleep, result.ready}, 2'b10);
      repeat (50) @(posedge pclk);
      slp <= 1'b0;
      t0 = cyc;
      wait_rdy(1'b1);
      check(inr(cyc - t0, 3999 * DIV, 4003 * DIV), 1);
      apb(1, CTRL_OFS, 2);
      repeat (3) @(posedge pclk);
      check({core_sleep, result.ready}, 2'b10);
      apb(1, CTRL_OFS, 0);
      wait_rdy(1'b1);
      check(core_sleep, 1'b0);
      apb(1, CTRL_OFS, 1);
      repeat (2) @(posedge pclk);
      check(result.ready, 1'b0);
      results();
   end
endmodule
